// File: inc/lfw_pkg.sv
package lfw_pkg;
  // special-function register offsets
  localparam logic [7:0] LFW_MODE_ADDR = 8'hA4;
  localparam logic [7:0] LFW_ANT_ADDR  = 8'hB2;
  localparam logic [7:0] LFW_GAIN_ADDR = 8'hC6;

  // mode register fields
  localparam int LFW_MODE_LOAD_EN  = 7;
  localparam int LFW_MODE_TRIM_LD  = 6;
  localparam int LFW_MODE_PURGE    = 5;
  localparam int LFW_MODE_AMP_CONT = 4;
  localparam int LFW_MODE_WAKE_HI  = 3;
  localparam int LFW_MODE_WAKE_LO  = 2;
  localparam int LFW_MODE_PROT_HI  = 1;
  localparam int LFW_MODE_PROT_LO  = 0;

  // antenna register fields
  localparam int LFW_ANT_TEST_HI = 7;
  localparam int LFW_ANT_TEST_LO = 6;
  localparam int LFW_ANT_CAP_HI  = 5;

  // gain register fields
  localparam int         LFW_GAIN_ATT_ON = 5;
  localparam int         LFW_GAIN_LVL_HI = 3;
  localparam logic [7:0] LFW_GAIN_MASK   = 8'h2F;

  localparam logic [7:0] LFW_REG_RESET = 8'h00;

  // timing, in nanoseconds and in 8 ns clock cycles
  localparam int LFW_CLK_NS       = 8;
  localparam int LFW_SNIFF_ON_NS  = 150000;
  localparam int LFW_SNIFF_INT_NS = 2200000;
  localparam int LFW_PRE_NS       = 1000000;
  localparam int LFW_END_MULT     = 3;
  localparam int LFW_SNIFF_ON_CYC  = (LFW_SNIFF_ON_NS + LFW_CLK_NS - 1) / LFW_CLK_NS;
  localparam int LFW_SNIFF_INT_CYC = (LFW_SNIFF_INT_NS + LFW_CLK_NS - 1) / LFW_CLK_NS;
  localparam int LFW_PRE_CYC       = LFW_PRE_NS / LFW_CLK_NS;

  typedef enum logic [1:0] {
    LFW_TEST_OFF  = 2'b00,
    LFW_TEST_SCLK = 2'b01,
    LFW_TEST_ASK  = 2'b10,
    LFW_TEST_RSSI = 2'b11
  } lfw_test_e;

  typedef enum logic [1:0] {
    LFW_WAKE_NEVER = 2'b00,
    LFW_WAKE_SYNC  = 2'b01,
    LFW_WAKE_ID    = 2'b10,
    LFW_WAKE_DATA  = 2'b11
  } lfw_wake_e;

  typedef enum logic [1:0] {
    LFW_PROT_PWM = 2'b00,
    LFW_PROT_1A  = 2'b01,
    LFW_PROT_1B  = 2'b10,
    LFW_PROT_1C  = 2'b11
  } lfw_prot_e;

  typedef enum logic [1:0] {
    LFW_ST_SLEEP = 2'b00,
    LFW_ST_SNIFF = 2'b01,
    LFW_ST_RECV  = 2'b10
  } lfw_state_e;
endpackage

// File: logic/lfw_ctrl.sv
`timescale 1ns/1ps
module lfw_ctrl
  import lfw_pkg::*;
#(
  parameter int SNIFF_ON_CYC  = lfw_pkg::LFW_SNIFF_ON_CYC,
  parameter int SNIFF_INT_CYC = lfw_pkg::LFW_SNIFF_INT_CYC,
  parameter int PRE_CYC       = lfw_pkg::LFW_PRE_CYC
)(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                sfr_wr,
  input  wire logic [7:0]          sfr_addr,
  input  wire logic [7:0]          sfr_wdata,
  input  wire logic                sfr_rd,
  output logic      [7:0]          sfr_rdata,
  input  wire logic                lf_detect,
  input  wire logic                sclk_mon,
  input  wire logic                ask_mon,
  input  wire logic                rssi_mon,
  output logic                     amp_power,
  output logic                     detector_purge,
  output logic                     mcu_wake,
  output logic                     rx_end,
  output logic                     test_monitor_out,
  output logic      [5:0]          antenna_cap_value,
  output logic                     attenuator_on,
  output logic      [3:0]          attenuator_level,
  output lfw_pkg::lfw_wake_e       mcu_wake_point,
  output lfw_pkg::lfw_prot_e       rx_protocol_select,
  output logic                     trim_load_general,
  output logic                     trim_load_slicer
);
  import lfw_pkg::*;

  localparam logic [23:0] ON_MAX  = 24'(SNIFF_ON_CYC - 1);
  localparam logic [23:0] INT_MAX = 24'(SNIFF_INT_CYC - 1);
  localparam logic [23:0] END_MAX = 24'(LFW_END_MULT * PRE_CYC);

  logic [7:0] mode_reg;
  logic [7:0] ant_reg;
  logic [7:0] gain_reg;
  lfw_state_e state_reg;
  logic [23:0] cnt_reg;

  function automatic logic hit(input logic [7:0] a);
    return sfr_wr && (sfr_addr == a);
  endfunction

  wire load_en = mode_reg[LFW_MODE_LOAD_EN];
  wire trim_ld = mode_reg[LFW_MODE_TRIM_LD];
  wire purge   = mode_reg[LFW_MODE_PURGE];

  // mode register: bit 7 always writable, the rest gated by the stored bit 7
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mode_reg <= LFW_REG_RESET;
    else if (hit(LFW_MODE_ADDR))
    begin
      mode_reg[LFW_MODE_LOAD_EN] <= sfr_wdata[LFW_MODE_LOAD_EN];
      if (load_en)
        mode_reg[LFW_MODE_TRIM_LD:0] <= sfr_wdata[LFW_MODE_TRIM_LD:0];
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ant_reg <= LFW_REG_RESET;
    else if (hit(LFW_ANT_ADDR) && trim_ld)
      ant_reg <= sfr_wdata;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      gain_reg <= LFW_REG_RESET;
    else if (hit(LFW_GAIN_ADDR))
      gain_reg <= sfr_wdata & LFW_GAIN_MASK;

  // only the gain register reads back; write-only ones read zero
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      sfr_rdata <= LFW_REG_RESET;
    else if (sfr_rd)
      sfr_rdata <= (sfr_addr == LFW_GAIN_ADDR) ? gain_reg : LFW_REG_RESET;

  // sniff sequencer: sleep interval, sniff-on window, receive until silence
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      state_reg <= LFW_ST_SLEEP;
      cnt_reg   <= '0;
    end
    else if (purge)
    begin
      state_reg <= LFW_ST_SLEEP;
      cnt_reg   <= '0;
    end
    else
      unique case (state_reg)
        LFW_ST_SLEEP:
          if (cnt_reg >= INT_MAX)
          begin
            state_reg <= LFW_ST_SNIFF;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 24'h000001;
        LFW_ST_SNIFF:
          if (lf_detect)
          begin
            state_reg <= LFW_ST_RECV;
            cnt_reg   <= '0;
          end
          else if (cnt_reg >= ON_MAX)
          begin
            state_reg <= LFW_ST_SLEEP;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 24'h000001;
        LFW_ST_RECV:
          if (lf_detect)
            cnt_reg <= '0;
          else if (cnt_reg >= END_MAX)
          begin
            state_reg <= LFW_ST_SLEEP;
            cnt_reg   <= '0;
          end
          else
            cnt_reg <= cnt_reg + 24'h000001;
        default:
        begin
          state_reg <= LFW_ST_SLEEP;
          cnt_reg   <= '0;
        end
      endcase

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      amp_power      <= 1'b0;
      detector_purge <= 1'b0;
    end
    else
    begin
      detector_purge <= purge;
      amp_power      <= !purge && (mode_reg[LFW_MODE_AMP_CONT]
                        || state_reg != LFW_ST_SLEEP);
    end

  // wake pulse: pulse-width mode wakes on first detect inside the window;
  // pattern-matching protocol modes never raise it; one/zero decisions against
  // the preamble length are left to software after the wake
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      mcu_wake <= 1'b0;
      rx_end   <= 1'b0;
    end
    else
    begin
      mcu_wake <= !purge && state_reg == LFW_ST_SNIFF && lf_detect
                  && rx_protocol_select == LFW_PROT_PWM;
      rx_end   <= !purge && state_reg == LFW_ST_RECV && !lf_detect
                  && cnt_reg >= END_MAX;
    end

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      test_monitor_out <= 1'b0;
    else
      unique case (lfw_test_e'(ant_reg[LFW_ANT_TEST_HI:LFW_ANT_TEST_LO]))
        LFW_TEST_OFF:  test_monitor_out <= 1'b0;
        LFW_TEST_SCLK: test_monitor_out <= sclk_mon;
        LFW_TEST_ASK:  test_monitor_out <= ask_mon;
        LFW_TEST_RSSI: test_monitor_out <= rssi_mon;
      endcase

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      antenna_cap_value  <= '0;
      attenuator_on      <= 1'b0;
      attenuator_level   <= '0;
      mcu_wake_point     <= LFW_WAKE_NEVER;
      rx_protocol_select <= LFW_PROT_PWM;
      trim_load_general  <= 1'b0;
      trim_load_slicer   <= 1'b0;
    end
    else
    begin
      antenna_cap_value  <= ant_reg[LFW_ANT_CAP_HI:0];
      attenuator_on      <= gain_reg[LFW_GAIN_ATT_ON];
      attenuator_level   <= gain_reg[LFW_GAIN_LVL_HI:0];
      mcu_wake_point     <= lfw_wake_e'(mode_reg[LFW_MODE_WAKE_HI:LFW_MODE_WAKE_LO]);
      rx_protocol_select <= lfw_prot_e'(mode_reg[LFW_MODE_PROT_HI:LFW_MODE_PROT_LO]);
      trim_load_general  <= trim_ld;
      trim_load_slicer   <= !trim_ld;
    end

  chk_load_gate_mode: assert property (@(posedge clk) disable iff (!rst_n)
    hit(LFW_MODE_ADDR) && !load_en |=> $stable(mode_reg[6:0]))
    else $error("mode fields changed while load enable clear");
  chk_ant_gate: assert property (@(posedge clk) disable iff (!rst_n)
    hit(LFW_ANT_ADDR) && !trim_ld |=> $stable(ant_reg))
    else $error("antenna register changed while trim load clear");
  chk_load_bit_write: assert property (@(posedge clk) disable iff (!rst_n)
    hit(LFW_MODE_ADDR) |=> mode_reg[7] == $past(sfr_wdata[7]))
    else $error("load enable did not take written value");
  chk_purge_amp_off: assert property (@(posedge clk) disable iff (!rst_n)
    purge |=> !amp_power && detector_purge)
    else $error("amplifier powered during purge");
  chk_amp_cont: assert property (@(posedge clk) disable iff (!rst_n)
    mode_reg[4] && !purge |=> amp_power)
    else $error("continuous amplifier power not applied");
  chk_sniff_len: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == LFW_ST_SNIFF |-> cnt_reg <= ON_MAX)
    else $error("sniff window overran");
  chk_end_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == LFW_ST_RECV && cnt_reg < END_MAX |=> !rx_end)
    else $error("end reported before silence timeout");
  chk_pwm_wake: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == LFW_ST_SNIFF && lf_detect && !purge && rx_protocol_select == LFW_PROT_PWM
    |=> mcu_wake ##1 state_reg == LFW_ST_RECV)
    else $error("no wake on detect in sniff window");
  chk_test_off: assert property (@(posedge clk) disable iff (!rst_n)
    ant_reg[7:6] == 2'b00 |=> !test_monitor_out)
    else $error("test monitor active while disabled");
  chk_gain_map: assert property (@(posedge clk) disable iff (!rst_n)
    hit(LFW_GAIN_ADDR) |=> ##1 attenuator_level == $past(sfr_wdata[3:0], 2))
    else $error("attenuator level mismatch");

  cov_wake: cover property (@(posedge clk) disable iff (!rst_n) mcu_wake);
  cov_end: cover property (@(posedge clk) disable iff (!rst_n) rx_end);
  cov_ant_wr: cover property (@(posedge clk) disable iff (!rst_n) hit(LFW_ANT_ADDR) && trim_ld);
  cov_gated: cover property (@(posedge clk) disable iff (!rst_n) hit(LFW_MODE_ADDR) && !load_en);
endmodule // lfw_ctrl

// File: test/lfw_tx_model.sv
`timescale 1ns/1ps
module lfw_tx_model #(
  parameter int UNIT = 4
)(
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [3:0] bits,
  output logic            lf_detect,
  output logic            busy
);
  // all lengths derive from one unit, so any drift scales every pulse alike except the one fixed extra cycle of the first burst
  task automatic hold(input logic lvl, input int cyc);
    lf_detect = lvl;
    repeat (cyc) @(posedge clk);
    #1;
  endtask
  initial
  begin
    lf_detect = 1'b0;
    busy      = 1'b0;
    forever
    begin
      @(posedge clk);
      if (start === 1'b1)
      begin
        busy = 1'b1;
        #1;
        hold(1'b1, 5 * UNIT + 1);
        hold(1'b0, UNIT);
        hold(1'b1, UNIT);
        for (int i = 3; i >= 0; i--)
        begin
          hold(1'b0, UNIT);
          hold(1'b1, bits[i] ? 3 * UNIT / 2 : UNIT / 2);
        end
        lf_detect = 1'b0;
        busy      = 1'b0;
      end
    end
  end
endmodule // lfw_tx_model

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import lfw_pkg::*;
  localparam int SON  = 4;
  localparam int SINT = 8;
  localparam int PRE  = 4;
  logic       clk, rst_n, sfr_wr, sfr_rd, lf_detect, start, busy;
  logic       sclk_mon, ask_mon, rssi_mon, amp_power, detector_purge;
  logic       mcu_wake, rx_end, test_monitor_out, attenuator_on;
  logic       trim_load_general, trim_load_slicer;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [5:0] antenna_cap_value;
  logic [3:0] attenuator_level, bits, e;
  lfw_wake_e  mcu_wake_point;
  lfw_prot_e  rx_protocol_select;
  int         err_total, tests_run, wakes, n;

  lfw_ctrl #(.SNIFF_ON_CYC(SON), .SNIFF_INT_CYC(SINT), .PRE_CYC(PRE)) lfw_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .lf_detect(lf_detect), .sclk_mon(sclk_mon),
    .ask_mon(ask_mon), .rssi_mon(rssi_mon), .amp_power(amp_power),
    .detector_purge(detector_purge), .mcu_wake(mcu_wake), .rx_end(rx_end),
    .test_monitor_out(test_monitor_out), .antenna_cap_value(antenna_cap_value),
    .attenuator_on(attenuator_on), .attenuator_level(attenuator_level),
    .mcu_wake_point(mcu_wake_point), .rx_protocol_select(rx_protocol_select),
    .trim_load_general(trim_load_general), .trim_load_slicer(trim_load_slicer));
  lfw_tx_model #(.UNIT(PRE)) lfw_tx_model_inst (
    .clk(clk), .start(start), .bits(bits), .lf_detect(lf_detect), .busy(busy));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
    if (mcu_wake === 1'b1) wakes++;

  task tick(input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // outputs follow the register one edge later, so two edges are let pass
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(2);
  endtask
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a; sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    tick(1);
    check(sfr_rdata, exp, "read");
  endtask
  task run_len(input logic lvl, output int cnt);
    cnt = 0;
    while (amp_power === lvl && cnt < 50)
    begin
      cnt++;
      tick(1);
    end
  endtask
  task send(input logic [3:0] b);
    bits = b; start = 1'b1;
    tick(1);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 500)
    begin
      n++;
      tick(1);
    end
  endtask

  task test_reset;
    check({2'b0, antenna_cap_value}, 8'h00, "ant rst");
    check({3'b0, attenuator_on, attenuator_level}, 8'h00, "gain rst");
    check({4'b0, mcu_wake_point, rx_protocol_select}, 8'h00, "mode rst");
    check({6'b0, trim_load_general, trim_load_slicer}, 8'h01, "trim rst");
    $display("reset test done");
  endtask
  task test_sniff;
    run_len(1'b1, n);
    run_len(1'b0, n);
    run_len(1'b1, n);
    check(8'(n), 8'(SON), "sniff on");
    run_len(1'b0, n);
    check(8'(n), 8'(SINT), "sniff gap");
    $display("sniff test done");
  endtask
  task test_gain;
    wr(LFW_GAIN_ADDR, 8'hFF);
    check({3'b0, attenuator_on, attenuator_level}, 8'h1F, "gain max");
    rd_chk(LFW_GAIN_ADDR, 8'h2F);
    wr(LFW_GAIN_ADDR, 8'h10);
    check({3'b0, attenuator_on, attenuator_level}, 8'h00, "gain min");
    wr(8'h55, 8'hFF);
    rd_chk(LFW_GAIN_ADDR, 8'h00);
    $display("gain test done");
  endtask
  task test_mode;
    wr(LFW_MODE_ADDR, 8'h7F);
    check({4'b0, mcu_wake_point, rx_protocol_select}, 8'h00, "locked");
    check({6'b0, trim_load_general, detector_purge}, 8'h00, "locked");
    wr(LFW_MODE_ADDR, 8'h80);
    for (int v = 0; v < 4; v++)
    begin
      wr(LFW_MODE_ADDR, 8'(8'h80 | (v << 2) | (3 - v)));
      check({6'b0, mcu_wake_point}, 8'(v), "wake sel");
      check({6'b0, rx_protocol_select}, 8'(3 - v), "prot sel");
    end
    wr(LFW_ANT_ADDR, 8'h3F);
    check({2'b0, antenna_cap_value}, 8'h00, "ant locked");
    wr(LFW_MODE_ADDR, 8'hC0);
    check({6'b0, trim_load_general, trim_load_slicer}, 8'h02, "trim sel");
    $display("mode test done");
  endtask
  task test_ant;
    for (int s = 0; s < 4; s++)
    begin
      wr(LFW_ANT_ADDR, 8'((s << 6) | (21 + s)));
      check({2'b0, antenna_cap_value}, 8'(21 + s), "ant cap");
      for (int p = 0; p < 2; p++)
      begin
        {sclk_mon, ask_mon, rssi_mon} = p ? 3'b010 : 3'b101;
        e = {rssi_mon, ask_mon, sclk_mon, 1'b0};
        tick(2);
        check({7'b0, test_monitor_out}, {7'b0, e[s]}, "monitor");
      end
    end
    $display("antenna test done");
  endtask
  task test_wake;
    int w0;
    wr(LFW_MODE_ADDR, 8'h80);
    w0 = wakes;
    send(4'hA);
    check(8'(wakes - w0), 8'd1, "wake");
    check({7'b0, amp_power}, 8'h01, "amp recv");
    n = 0;
    while (rx_end !== 1'b1 && n < 50)
    begin
      n++;
      tick(1);
    end
    check(8'(n >= 3 * PRE && n <= 3 * PRE + 2), 8'd1, "end");
    $display("wake test done");
  endtask
  task test_purge;
    int w0;
    wr(LFW_MODE_ADDR, 8'hB0);
    check({6'b0, detector_purge, amp_power}, 8'h02, "purge");
    w0 = wakes;
    send(4'h5);
    check(8'(wakes - w0), 8'd0, "purged wake");
    wr(LFW_MODE_ADDR, 8'h90);
    run_len(1'b1, n);
    check(8'(n), 8'd50, "amp cont");
    $display("purge test done");
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_total++;
    complete_run;
  end
  initial
  begin
    rst_n = 1'b0; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00;
    start = 1'b0; bits = 4'h0; sclk_mon = 1'b0; ask_mon = 1'b0; rssi_mon = 1'b0;
    tick(20);
    rst_n = 1'b1;
    tick(1);
    test_reset;
    test_sniff;
    test_gain;
    test_mode;
    test_ant;
    test_wake;
    test_purge;
    complete_run;
  end
endmodule // tb
